// file: logic/mtc_pkg.sv
// How it works
// RULE_01 - read port A address is micro-instruction bits 4..12, used at decode phase
// RULE_02 - read port B address is micro-instruction bits 13..21, used at decode phase
// RULE_03 - write select bits 22..30 load the write address latch at primitive time
// RULE_04 - a trap sets taking-trap, clears primitive-good and both enable flags
// RULE_05 - a trap disables auxiliary conditions and sets retry-in-progress if retry enabled
// RULE_06 - after a trap the pipe restarts at 16X, X from a lookup table
// RULE_07 - while trapping, register-file writes and counter increment are blocked
// RULE_08 - when the fetched micro-instruction is ready, trap flags clear and sequencing resumes
// RULE_09 - monitor bits 48,50,53,56,59,62 and user bit 51 are catchable
// RULE_10 - catcher rank enabled by code 13 or job-mode trap; it blocks condition inputs
// RULE_11 - conditions held in the rank are strobed into the registers once disabled
// RULE_12 - a disabled rank is a 50 ns delay; instruction exit disables it
// RULE_13 - a set catchable bit stays set and traps only with catchable enable
// RULE_14 - catchable enable set by code 6 or exit; cleared by ring field, A, traps
// RULE_15 - other bits are non-catchable; they trap only with non-catchable enable
// RULE_16 - non-catchable enable set by code 7 or exit; cleared by code A or traps
// RULE_17 - user bits 50,54,58,59,60 and ring-zero monitor bit 60 need both enables
// RULE_18 - monitor register reads into top 16 operand bits at process-state location 05
// RULE_19 - writing top 16 bits of location 05 writes the monitor register 50 ns later
// RULE_20 - monitor bits 50 and 53 set whenever their inputs assert; code routes them through the rank, which holds them while enabled
// RULE_21 - monitor bit 51 sets on descriptor length over 63 with code 8
// RULE_22 - monitor bit 52 sets on translator address error 200 ns after primitive time
// RULE_23 - trap request is OR of set bits gated by enables; reset clears the rank
package mtc_pkg;
  localparam int CLK_NS = 40;
  localparam int DELAY_NS = 50;
  localparam int DELAY_CYC = (DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_ERR_NS = 200;
  localparam int ADDR_ERR_CYC = (ADDR_ERR_NS + CLK_NS - 1) / CLK_NS;
  localparam int RGA_LO = 4;
  localparam int RGB_LO = 13;
  localparam int RGC_LO = 22;
  localparam int SEL_W = 9;
  localparam logic [8:0] MON_LOC = 9'h005;
  localparam int COND_BASE = 48;
  localparam logic [5:0] AUX_CATCH_EN = 6'h06;
  localparam logic [5:0] AUX_NCATCH_EN = 6'h07;
  localparam logic [5:0] AUX_DESC_CHK = 6'h08;
  localparam logic [5:0] AUX_RANK_EN = 6'h13;
  localparam logic [3:0] EXT_DISABLE = 4'hA;
  localparam logic [6:0] DESC_MAX = 7'h3F;
  // bit index = condition number - 48
  localparam logic [15:0] MON_CATCH = 16'h4925;
  localparam logic [15:0] USR_CATCH = 16'h0008;
  localparam logic [15:0] USR_BOTH = 16'h1C44;
  localparam int MON_B51 = 3;
  localparam int MON_B52 = 4;
  localparam int MON_B60 = 12;
  localparam logic [7:0] TRAP_BASE = 8'h16;
  localparam logic [3:0] TRAP_X_COND = 4'h0;
  localparam logic [3:0] TRAP_X_CATCH = 4'h2;
  localparam logic [3:0] TRAP_X_OTHER = 4'h4;
  localparam logic [15:0] ZERO16 = 16'h0000;
endpackage : mtc_pkg

// file: logic/mtc_unit.sv
`timescale 1ns/1ps
module mtc_unit (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [31:0] i_micro,
  input wire logic i_decode_phase,
  input wire logic i_primitive,
  input wire logic [5:0] i_aux_code,
  input wire logic [3:0] i_ext_code,
  input wire logic i_ring_field,
  input wire logic i_instr_exit,
  input wire logic i_job_mode,
  input wire logic i_retry_enable,
  input wire logic i_ring_zero_a_load,
  input wire logic i_other_trap,
  input wire logic i_cs_ready,
  input wire logic [15:0] i_mon_cond_in,
  input wire logic [15:0] i_usr_cond_in,
  input wire logic [6:0] i_desc_len,
  input wire logic i_addr_spec_err,
  input wire logic [8:0] i_wr_addr,
  input wire logic i_wr_hi,
  input wire logic [15:0] i_wr_data,
  input wire logic i_process_state_select,
  input wire logic [8:0] i_rd_addr,
  output logic [8:0] o_read_port_a_select,
  output logic [8:0] o_read_port_b_select,
  output logic [8:0] o_write_address_latch,
  output logic [15:0] o_monitor_condition,
  output logic [15:0] o_user_condition,
  output logic [15:0] o_operand_hi,
  output logic o_taking_trap,
  output logic o_primitive_good,
  output logic o_catch_en,
  output logic o_ncatch_en,
  output logic o_aux_disable,
  output logic o_retry_in_progress,
  output logic o_rf_write_block,
  output logic o_pc_inc_block,
  output logic o_restart,
  output logic [11:0] o_restart_addr,
  output logic o_trap_req
);
  typedef struct packed {
    logic [8:0] read_port_a_select;
    logic [8:0] read_port_b_select;
    logic [8:0] write_address_latch;
    logic [15:0] mon;
    logic [15:0] usr;
    logic [15:0] rank_mon;
    logic [15:0] rank_usr;
    logic rank_en;
    logic catch_en;
    logic ncatch_en;
    logic taking;
    logic prim_good;
    logic aux_dis;
    logic retry;
    logic restart;
    logic [11:0] raddr;
    logic [15:0] opnd;
    logic wr_pend;
    logic [15:0] wr_data;
    logic [3:0] aerr_cnt;
    logic trap_req;
  } mtc_state_t;
  mtc_state_t q;
  mtc_state_t d;
  logic [15:0] mon_req;
  logic [15:0] usr_req;
  logic [15:0] usr_single;
  logic trap_now;
  logic [3:0] trap_x;
  logic unused_hi;
  assign unused_hi = i_micro[31] | (|i_micro[3:0]);
  // trap-address lookup: low digit from the highest-priority cause
  always_comb begin
    trap_x = mtc_pkg::TRAP_X_COND;
    if (i_other_trap) begin
      trap_x = mtc_pkg::TRAP_X_OTHER;
    end else if (|(q.mon & mtc_pkg::MON_CATCH) || |(q.usr & mtc_pkg::USR_CATCH)) begin
      trap_x = mtc_pkg::TRAP_X_CATCH;
    end
  end
  always_comb begin
    usr_single = q.usr & ~mtc_pkg::USR_BOTH;
    mon_req = q.mon & ((q.catch_en ? mtc_pkg::MON_CATCH : mtc_pkg::ZERO16)
      | (q.ncatch_en ? ~mtc_pkg::MON_CATCH : mtc_pkg::ZERO16)); // [RULE_13] [RULE_15]
    if (i_ring_zero_a_load && !(q.catch_en && q.ncatch_en)) begin
      mon_req[mtc_pkg::MON_B60] = 1'b0; // [RULE_17]
    end
    usr_req = (usr_single & ((q.catch_en ? mtc_pkg::USR_CATCH : mtc_pkg::ZERO16)
      | (q.ncatch_en ? ~mtc_pkg::USR_CATCH : mtc_pkg::ZERO16)))
      | (q.usr & mtc_pkg::USR_BOTH & {16{q.catch_en & q.ncatch_en}}); // [RULE_17]
    trap_now = (|mon_req) | (|usr_req) | i_other_trap; // [RULE_23]
  end
  always_comb begin
    d = q;
    d.restart = 1'b0;
    d.read_port_a_select = i_decode_phase ? i_micro[mtc_pkg::RGA_LO +: mtc_pkg::SEL_W] : q.read_port_a_select; // [RULE_01]
    d.read_port_b_select = i_decode_phase ? i_micro[mtc_pkg::RGB_LO +: mtc_pkg::SEL_W] : q.read_port_b_select; // [RULE_02]
    if (i_primitive) begin
      d.write_address_latch = i_micro[mtc_pkg::RGC_LO +: mtc_pkg::SEL_W]; // [RULE_03]
    end
    // rank: pure one-cycle delay when open, a holding latch when enabled
    if (q.rank_en) begin
      d.rank_mon = q.rank_mon | (i_mon_cond_in & mtc_pkg::MON_CATCH); // [RULE_11]
      d.rank_usr = q.rank_usr | (i_usr_cond_in & mtc_pkg::USR_CATCH);
    end else begin
      d.rank_mon = i_mon_cond_in & mtc_pkg::MON_CATCH; // [RULE_12] [RULE_09]
      d.rank_usr = i_usr_cond_in & mtc_pkg::USR_CATCH;
      d.mon = q.mon | q.rank_mon; // [RULE_11]
      d.usr = q.usr | q.rank_usr;
    end
    d.mon = d.mon | (i_mon_cond_in & ~mtc_pkg::MON_CATCH); // [RULE_20]
    d.usr = d.usr | (i_usr_cond_in & ~mtc_pkg::USR_CATCH);
    if (i_aux_code == mtc_pkg::AUX_DESC_CHK && i_desc_len > mtc_pkg::DESC_MAX
        && i_primitive) begin
      d.mon[mtc_pkg::MON_B51] = 1'b1; // [RULE_21]
    end
    // translator error sets bit 52 after the fixed delay
    // the bit lands even when a new error reloads the count in the same cycle
    if (q.aerr_cnt == 4'h1) begin
      d.mon[mtc_pkg::MON_B52] = 1'b1; // [RULE_22]
    end
    if (i_addr_spec_err && i_primitive) begin
      d.aerr_cnt = 4'(mtc_pkg::ADDR_ERR_CYC);
    end else if (q.aerr_cnt != 4'h0) begin
      d.aerr_cnt = q.aerr_cnt - 4'h1;
    end
    // monitor write lands one cycle (50 ns rounded) after primitive time
    d.wr_pend = i_primitive && i_wr_hi && i_wr_addr == mtc_pkg::MON_LOC;
    d.wr_data = i_wr_data;
    if (q.wr_pend) begin
      d.mon = q.wr_data; // [RULE_19]
    end
    d.opnd = (i_process_state_select && i_rd_addr == mtc_pkg::MON_LOC)
      ? q.mon : mtc_pkg::ZERO16; // [RULE_18]
    if (i_aux_code == mtc_pkg::AUX_CATCH_EN || i_instr_exit) begin
      d.catch_en = 1'b1; // [RULE_14]
    end
    if (i_aux_code == mtc_pkg::AUX_NCATCH_EN || i_instr_exit) begin
      d.ncatch_en = 1'b1; // [RULE_16]
    end
    if (i_ring_field || i_ext_code == mtc_pkg::EXT_DISABLE) begin
      d.catch_en = 1'b0; // [RULE_14]
    end
    if (i_ext_code == mtc_pkg::EXT_DISABLE) begin
      d.ncatch_en = 1'b0; // [RULE_16]
    end
    if (i_aux_code == mtc_pkg::AUX_RANK_EN) begin
      d.rank_en = 1'b1; // [RULE_10]
    end
    if (i_instr_exit) begin
      d.rank_en = 1'b0; // [RULE_12]
    end
    d.trap_req = trap_now;
    if (trap_now && !q.taking) begin
      d.taking = 1'b1; // [RULE_04]
      d.prim_good = 1'b0;
      d.catch_en = 1'b0;
      d.ncatch_en = 1'b0;
      d.aux_dis = 1'b1; // [RULE_05]
      d.retry = i_retry_enable ? 1'b1 : q.retry;
      d.restart = 1'b1; // [RULE_06]
      d.raddr = {mtc_pkg::TRAP_BASE, trap_x};
      if (i_job_mode) begin
        d.rank_en = 1'b1; // [RULE_10]
      end
    end else if (q.taking && i_cs_ready) begin
      d.taking = 1'b0; // [RULE_08]
      d.prim_good = 1'b1;
      d.aux_dis = 1'b0;
      d.retry = 1'b0;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0; // [RULE_23]
      q.prim_good <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign o_read_port_a_select = q.read_port_a_select;
  assign o_read_port_b_select = q.read_port_b_select;
  assign o_write_address_latch = q.write_address_latch;
  assign o_monitor_condition = q.mon;
  assign o_user_condition = q.usr;
  assign o_operand_hi = q.opnd;
  assign o_taking_trap = q.taking;
  assign o_primitive_good = q.prim_good;
  assign o_catch_en = q.catch_en;
  assign o_ncatch_en = q.ncatch_en;
  assign o_aux_disable = q.aux_dis;
  assign o_retry_in_progress = q.retry;
  assign o_rf_write_block = q.taking; // [RULE_07]
  assign o_pc_inc_block = q.taking; // [RULE_07]
  assign o_restart = q.restart;
  assign o_restart_addr = q.raddr;
  assign o_trap_req = q.trap_req;

  a_trap_blocks: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_taking_trap |-> o_rf_write_block && o_pc_inc_block)
    else $error("blocks not held while trapping"); // [RULE_07]
  a_trap_entry: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (trap_now && !q.taking) |=> q.taking && !q.prim_good && !q.catch_en && !q.ncatch_en)
    else $error("trap entry flags wrong"); // [RULE_04]
  a_trap_vector: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_restart |-> o_restart_addr[11:4] == mtc_pkg::TRAP_BASE)
    else $error("restart address outside 16X"); // [RULE_06]
  a_trap_leave: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.taking && i_cs_ready && !trap_now) |=> !q.taking && q.prim_good)
    else $error("trap not released"); // [RULE_08]
  a_mon_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_primitive && i_wr_hi && i_wr_addr == mtc_pkg::MON_LOC) ##1 1'b1
    |=> o_monitor_condition == $past(i_wr_data, 2))
    else $error("monitor write lost"); // [RULE_19]
  a_rank_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.rank_en && q.rank_mon[0] && !i_instr_exit && !(trap_now && !q.taking)) |=> q.rank_mon[0])
    else $error("caught condition dropped"); // [RULE_11]
  a_catch_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!q.catch_en && !q.ncatch_en && !i_other_trap) |-> !trap_now)
    else $error("trap without enable"); // [RULE_13]
  a_exit_enables: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_instr_exit && !i_ring_field && i_ext_code != mtc_pkg::EXT_DISABLE && !trap_now)
    |=> q.catch_en && q.ncatch_en)
    else $error("exit failed to enable"); // [RULE_14]
  a_rga_field: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_decode_phase |=> o_read_port_a_select == $past(i_micro[mtc_pkg::RGA_LO +: mtc_pkg::SEL_W])
    && o_read_port_b_select == $past(i_micro[mtc_pkg::RGB_LO +: mtc_pkg::SEL_W]))
    else $error("read select mismatch"); // [RULE_01]
  a_wr_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_03]
    i_primitive |=> o_write_address_latch == $past(i_micro[mtc_pkg::RGC_LO +: mtc_pkg::SEL_W]))
    else $error("write latch mismatch");
  a_restart_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_06]
    o_restart |=> !o_restart)
    else $error("restart pulse too long");
  a_retry_set: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_05]
    (trap_now && !q.taking && i_retry_enable) |=> o_retry_in_progress)
    else $error("retry flag not set");
  a_aux_disable: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_05]
    (trap_now && !q.taking) |=> o_aux_disable)
    else $error("aux conditions not disabled");
  a_taking_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_07]
    (q.taking && !i_cs_ready) |=> q.taking)
    else $error("trap dropped early");
  a_prim_good: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_08]
    !q.taking |-> o_primitive_good)
    else $error("primitive good low outside trap");
  a_operand_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_18]
    (i_process_state_select && i_rd_addr == mtc_pkg::MON_LOC)
    |=> o_operand_hi == $past(o_monitor_condition))
    else $error("operand read mismatch");
  a_desc_error: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_21]
    (i_primitive && i_aux_code == mtc_pkg::AUX_DESC_CHK && i_desc_len > mtc_pkg::DESC_MAX
    && !q.wr_pend) |=> o_monitor_condition[mtc_pkg::MON_B51])
    else $error("descriptor error not set");
  a_addr_error: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_22]
    (q.aerr_cnt == 4'h1 && !q.wr_pend) |=> o_monitor_condition[mtc_pkg::MON_B52])
    else $error("address error not set");
  a_rank_strobe: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_11]
    (!q.rank_en && q.rank_mon[0] && !q.wr_pend) |=> o_monitor_condition[0])
    else $error("rank not strobed");
  a_rank_block: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_10]
    (q.rank_en && !q.wr_pend) |=> (o_monitor_condition & mtc_pkg::MON_CATCH)
    == ($past(o_monitor_condition) & mtc_pkg::MON_CATCH))
    else $error("rank let a condition through");
  a_rank_delay: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_12]
    (!q.rank_en && i_mon_cond_in[0]) |=> q.rank_mon[0])
    else $error("rank delay lost a condition");
  a_exit_rank: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_12]
    (i_instr_exit && !(trap_now && !q.taking && i_job_mode)) |=> !q.rank_en)
    else $error("exit left rank enabled");
  a_rank_enable: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_10]
    (i_aux_code == mtc_pkg::AUX_RANK_EN && !i_instr_exit) |=> q.rank_en)
    else $error("rank not enabled");
  a_job_rank: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_10]
    (trap_now && !q.taking && i_job_mode) |=> q.rank_en)
    else $error("job mode trap left rank open");
  a_ring_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_14]
    i_ring_field |=> !o_catch_en)
    else $error("ring field kept catch enable");
  a_catch_set: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_14]
    (i_aux_code == mtc_pkg::AUX_CATCH_EN && !i_ring_field && i_ext_code != mtc_pkg::EXT_DISABLE
    && !(trap_now && !q.taking)) |=> o_catch_en)
    else $error("catch enable not set");
  a_ncatch_set: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_16]
    (i_aux_code == mtc_pkg::AUX_NCATCH_EN && i_ext_code != mtc_pkg::EXT_DISABLE
    && !(trap_now && !q.taking)) |=> o_ncatch_en)
    else $error("non-catchable enable not set");
  a_ext_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_16]
    (i_ext_code == mtc_pkg::EXT_DISABLE) |=> !o_catch_en && !o_ncatch_en)
    else $error("extended code kept an enable");
  a_ncatch_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_15]
    (!q.ncatch_en && !i_other_trap && (q.mon & mtc_pkg::MON_CATCH) == mtc_pkg::ZERO16
    && (q.usr & mtc_pkg::USR_CATCH) == mtc_pkg::ZERO16) |-> !trap_now)
    else $error("non-catchable trap without enable");
  a_mon_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_13]
    !q.wr_pend |=> (o_monitor_condition & $past(o_monitor_condition))
    == $past(o_monitor_condition))
    else $error("monitor bit dropped");
  // user bits have no write path here, so only reset may clear them
  a_usr_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_15]
    o_user_condition[0] |=> o_user_condition[0])
    else $error("user bit dropped");
  a_usr_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_15]
    1'b1 |=> (o_user_condition & $past(o_user_condition)) == $past(o_user_condition))
    else $error("user bits dropped");
  a_trap_req: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_23]
    trap_now |=> o_trap_req)
    else $error("trap request not raised");
endmodule : mtc_unit

// file: verif/mtc_seq_model.sv
`timescale 1ns/1ps
module mtc_seq_model (
  input wire logic i_clk,
  input wire logic i_restart,
  input wire logic i_slow,
  output logic o_cs_ready
);
  int cnt = -1;
  initial o_cs_ready = 1'b0;
  // trap routine fetch: ready rises 3 or 7 cycles after restart is sampled; ready is one cycle wide
  always @(posedge i_clk) begin
    o_cs_ready <= 1'b0;
    if (i_restart) begin
      cnt <= i_slow ? 6 : 2;
    end else if (cnt == 0) begin
      o_cs_ready <= 1'b1;
      cnt <= -1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule : mtc_seq_model

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_clk, i_rst_n, i_decode_phase, i_primitive, i_ring_field, i_instr_exit, i_job_mode;
  logic i_retry_enable, i_ring_zero_a_load, i_other_trap, i_cs_ready, i_addr_spec_err, i_wr_hi;
  logic i_process_state_select, slow;
  logic [31:0] i_micro;
  logic [5:0] i_aux_code;
  logic [3:0] i_ext_code;
  logic [15:0] i_mon_cond_in, i_usr_cond_in, i_wr_data;
  logic [6:0] i_desc_len;
  logic [8:0] i_wr_addr, i_rd_addr;
  logic [8:0] o_read_port_a_select, o_read_port_b_select, o_write_address_latch;
  logic [15:0] o_monitor_condition, o_user_condition, o_operand_hi;
  logic o_taking_trap, o_primitive_good, o_catch_en, o_ncatch_en, o_aux_disable;
  logic o_retry_in_progress, o_rf_write_block, o_pc_inc_block, o_restart, o_trap_req;
  logic [11:0] o_restart_addr;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_restart = 0;
  int r;

  mtc_unit DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_micro(i_micro), .i_decode_phase(i_decode_phase),
    .i_primitive(i_primitive), .i_aux_code(i_aux_code), .i_ext_code(i_ext_code),
    .i_ring_field(i_ring_field), .i_instr_exit(i_instr_exit), .i_job_mode(i_job_mode),
    .i_retry_enable(i_retry_enable), .i_ring_zero_a_load(i_ring_zero_a_load),
    .i_other_trap(i_other_trap), .i_cs_ready(i_cs_ready), .i_mon_cond_in(i_mon_cond_in),
    .i_usr_cond_in(i_usr_cond_in), .i_desc_len(i_desc_len), .i_addr_spec_err(i_addr_spec_err),
    .i_wr_addr(i_wr_addr), .i_wr_hi(i_wr_hi), .i_wr_data(i_wr_data),
    .i_process_state_select(i_process_state_select), .i_rd_addr(i_rd_addr),
    .o_read_port_a_select(o_read_port_a_select), .o_read_port_b_select(o_read_port_b_select),
    .o_write_address_latch(o_write_address_latch), .o_monitor_condition(o_monitor_condition),
    .o_user_condition(o_user_condition), .o_operand_hi(o_operand_hi),
    .o_taking_trap(o_taking_trap), .o_primitive_good(o_primitive_good),
    .o_catch_en(o_catch_en), .o_ncatch_en(o_ncatch_en), .o_aux_disable(o_aux_disable),
    .o_retry_in_progress(o_retry_in_progress), .o_rf_write_block(o_rf_write_block),
    .o_pc_inc_block(o_pc_inc_block), .o_restart(o_restart), .o_restart_addr(o_restart_addr),
    .o_trap_req(o_trap_req)
  );
  mtc_seq_model SEQ (.i_clk(i_clk), .i_restart(o_restart), .i_slow(slow), .o_cs_ready(i_cs_ready));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // restart is a one-cycle pulse, so it is counted at every edge
  always @(posedge i_clk) begin
    cycles++;
    if (o_restart === 1'b1) n_restart++;
    if (cycles == 3000) begin
      errors++;
      summarize();
    end
  end

  task step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task aux(input logic [5:0] a, input logic [3:0] e);
    i_aux_code = a;
    i_ext_code = e;
    i_primitive = 1'b1;
    step(1);
    i_aux_code = 6'h00;
    i_ext_code = 4'h0;
    i_primitive = 1'b0;
    step(1);
  endtask : aux

  task wr_mon(input logic [15:0] d);
    i_wr_addr = mtc_pkg::MON_LOC;
    i_wr_hi = 1'b1;
    i_wr_data = d;
    i_primitive = 1'b1;
    step(1);
    i_wr_hi = 1'b0;
    i_primitive = 1'b0;
    step(2);
  endtask : wr_mon

  task pulse(input logic [15:0] m, input logic [15:0] u);
    i_mon_cond_in = m;
    i_usr_cond_in = u;
    step(1);
    i_mon_cond_in = 16'h0000;
    i_usr_cond_in = 16'h0000;
  endtask : pulse

  task wait_restart(input logic [11:0] a);
    for (int k = 0; k < 20 && o_restart !== 1'b1; k++) step(1);
    chk("restart", 16'h0001, {15'h0000, o_restart});
    chk("restart_addr", {4'h0, a}, {4'h0, o_restart_addr});
  endtask : wait_restart

  task wait_done;
    for (int k = 0; k < 20 && o_taking_trap !== 1'b0; k++) step(1);
  endtask : wait_done

  initial begin
    {i_decode_phase, i_primitive, i_ring_field, i_instr_exit, i_job_mode} = 5'h00;
    {i_ring_zero_a_load, i_other_trap, i_addr_spec_err, i_wr_hi, slow} = 5'h00;
    {i_process_state_select, i_micro, i_aux_code, i_ext_code} = 43'h0;
    {i_mon_cond_in, i_usr_cond_in, i_wr_data, i_desc_len, i_wr_addr, i_rd_addr} = 73'h0;
    i_retry_enable = 1'b1;
    i_rst_n = 1'b0;
    step(3);
    i_rst_n = 1'b1;
    i_micro = {1'b0, 9'h1A5, 9'h0C3, 9'h15A, 4'h0};
    i_decode_phase = 1'b1;
    i_primitive = 1'b1;
    step(1);
    {i_decode_phase, i_primitive} = 2'h0;
    step(1);
    chk("port_a", 16'h015A, {7'h00, o_read_port_a_select});
    chk("port_b", 16'h00C3, {7'h00, o_read_port_b_select});
    chk("wr_latch", 16'h01A5, {7'h00, o_write_address_latch});
    wr_mon(16'h8001);
    chk("monitor", 16'h8001, o_monitor_condition);
    i_process_state_select = 1'b1;
    i_rd_addr = mtc_pkg::MON_LOC;
    step(2);
    chk("operand_hi", 16'h8001, o_operand_hi);
    wr_mon(16'h0000);
    aux(mtc_pkg::AUX_CATCH_EN, 4'h0);
    chk("catch_en", 16'h0001, {15'h0000, o_catch_en});
    pulse(16'h0004, 16'h0000);
    wait_restart(12'h162);
    chk("taking", 16'h0001, {15'h0000, o_taking_trap});
    chk("prim_good", 16'h0000, {15'h0000, o_primitive_good});
    chk("enables", 16'h0000, {14'h0000, o_catch_en, o_ncatch_en});
    chk("retry_aux", 16'h0003, {14'h0000, o_retry_in_progress, o_aux_disable});
    chk("blocks", 16'h0003, {14'h0000, o_rf_write_block, o_pc_inc_block});
    wait_done();
    chk("taking_end", 16'h0000, {15'h0000, o_taking_trap});
    chk("blocks_end", 16'h0000, {14'h0000, o_rf_write_block, o_pc_inc_block});
    r = n_restart;
    pulse(16'h0020, 16'h0000);
    step(6);
    chk("no_trap", r[15:0], n_restart[15:0]);
    chk("monitor_held", 16'h0024, o_monitor_condition);
    wr_mon(16'h0000);
    aux(mtc_pkg::AUX_NCATCH_EN, 4'h0);
    chk("ncatch_en", 16'h0001, {15'h0000, o_ncatch_en});
    aux(6'h00, mtc_pkg::EXT_DISABLE);
    chk("ext_clear", 16'h0000, {14'h0000, o_catch_en, o_ncatch_en});
    i_instr_exit = 1'b1;
    step(1);
    i_instr_exit = 1'b0;
    step(1);
    chk("exit_set", 16'h0003, {14'h0000, o_catch_en, o_ncatch_en});
    aux(6'h00, mtc_pkg::EXT_DISABLE);
    slow = 1'b1;
    aux(mtc_pkg::AUX_NCATCH_EN, 4'h0);
    r = n_restart;
    pulse(16'h0000, 16'h0004);
    step(6);
    chk("one_enable", r[15:0], n_restart[15:0]);
    aux(mtc_pkg::AUX_CATCH_EN, 4'h0);
    wait_restart(12'h160);
    wait_done();
    chk("slow_end", 16'h0000, {15'h0000, o_taking_trap});
    chk("user", 16'h0004, o_user_condition);
    aux(mtc_pkg::AUX_RANK_EN, 4'h0);
    pulse(16'h0001, 16'h0000);
    step(3);
    chk("rank_held", 16'h0000, o_monitor_condition);
    i_instr_exit = 1'b1;
    step(1);
    i_instr_exit = 1'b0;
    wait_restart(12'h160);
    chk("trap_req", 16'h0001, {15'h0000, o_trap_req});
    wait_done();
    chk("rank_strobe", 16'h0001, o_monitor_condition);
    i_desc_len = 7'h3F;
    aux(mtc_pkg::AUX_DESC_CHK, 4'h0);
    chk("desc_ok", 16'h0001, o_monitor_condition);
    i_desc_len = 7'h40;
    aux(mtc_pkg::AUX_DESC_CHK, 4'h0);
    i_desc_len = 7'h00;
    chk("desc_err", 16'h0009, o_monitor_condition);
    i_addr_spec_err = 1'b1;
    i_primitive = 1'b1;
    step(1);
    i_addr_spec_err = 1'b0;
    i_primitive = 1'b0;
    step(3);
    chk("addr_early", 16'h0009, o_monitor_condition);
    step(2);
    chk("addr_err", 16'h0019, o_monitor_condition);
    summarize();
  end
endmodule : tb_top
